// [rtl/cpurs_core.sv]
// Programmer-visible CPU state: general registers, fetch pointer, trace and
// mask level, condition flags, operand address forming, interrupt gating.
// Assumes the sequencer drives one request per port per cycle.
`timescale 1ns/100ps

// Behaviour
// - Eight identical 32-bit general registers, address or data use, 32/16/8-bit access.
// - Each register splits into upper and lower 16-bit halves, sixteen in all.
// - Each lower half splits into high and low bytes, sixteen in all.
// - 24-bit fetch pointer; fetch address always has bit 0 cleared.
// - Trace bit set raises a trace request after every finished instruction.
// - Mask level in bits 2..0; bits 6..3 reserved.
// - Writing the level register, except by store, refuses interrupts for 3 states.
// - Flag bit 7 masks all but nonmaskable; set when exception handling starts.
// - Flag bits 6 and 4 are plain software bits; bit 6 masks nothing.
// - Byte add/sub family sets half-carry from bit 3.
// - Word add/sub family sets half-carry from bit 11.
// - Longword add/sub family sets half-carry from bit 27.
// - Negative flag takes the result sign bit.
// - Zero flag set on zero result, cleared otherwise.
// - Overflow flag set on arithmetic overflow, cleared otherwise.
// - Carry gives add carry, subtract borrow, or shifted-out bit.
// - Carry acts as bit accumulator, loading bit 0..7 of a byte.
// - Decimal adjust treats a byte as two packed BCD digits.
// - Eight operand addressing modes are formed.
module cpurs_core #(
  parameter int HOLD_CNT = cpurs_pkg::HOLD_STATES
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // General register write and read
  input wire logic i_gr_wr,
  input wire cpurs_pkg::cpurs_gr_sel_t i_gr_wr_sel,
  input wire logic [31:0] i_gr_wr_data,
  input wire cpurs_pkg::cpurs_gr_sel_t i_gr_rd_sel,
  output logic [31:0] o_gr_rd_ff,
  // Operand address forming
  input wire cpurs_pkg::cpurs_ea_req_t i_ea,
  output logic o_ea_valid_ff,
  output logic [31:0] o_ea_addr_ff,
  // Fetch pointer
  input wire logic i_fp_load,
  input wire logic [23:0] i_fp_value,
  input wire logic i_fp_step,
  output logic [23:0] o_fetch_ptr_ff,
  output logic [23:0] o_fetch_addr_ff,
  // Control register operations
  input wire cpurs_pkg::cpurs_ctl_op_t i_ctl_op,
  input wire logic i_ctl_tml,
  input wire logic [7:0] i_ctl_imm,
  output logic [7:0] o_ctl_rd_ff,
  output logic [7:0] o_tml_ff,
  output logic [7:0] o_flags_ff,
  // Flag update
  input wire cpurs_pkg::cpurs_alu_req_t i_alu,
  output logic [31:0] o_alu_res_ff,
  // Exceptions and interrupts
  input wire logic i_instr_done,
  input wire logic i_exc_start,
  input wire logic i_nmi,
  input wire logic i_irq_req,
  input wire logic [2:0] i_irq_level,
  output logic o_irq_take_ff,
  output logic o_trace_req_ff
);
  import cpurs_pkg::*;

  if (HOLD_CNT < 1 || HOLD_CNT > 3) begin
    $error("HOLD_CNT must be 1 to 3");
  end

  logic [31:0] gr_ff [GR_NUM];
  logic [31:0] nxt_gr [GR_NUM];
  logic [1:0] hold_ff;
  logic [1:0] nxt_hold;

  function automatic logic [31:0] gr_merge(input logic [31:0] old, input logic [31:0] d,
                                          input cpurs_part_t part);
    logic [31:0] r;
    r = old;
    unique case (part)
      PART_LONG: r = d;
      PART_UPPER: r[31:16] = d[15:0];
      PART_LOWER: r[15:0] = d[15:0];
      PART_HIGH: r[15:8] = d[7:0];
      PART_LOW: r[7:0] = d[7:0];
      default: r = old;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] gr_pick(input logic [31:0] v, input cpurs_part_t part);
    logic [31:0] r;
    r = 32'h00000000;
    unique case (part)
      PART_LONG: r = v;
      PART_UPPER: r[15:0] = v[31:16];
      PART_LOWER: r[15:0] = v[15:0];
      PART_HIGH: r[7:0] = v[15:8];
      PART_LOW: r[7:0] = v[7:0];
      default: r = 32'h00000000;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Operand address forming
  logic [31:0] ea_base;
  logic [31:0] ea_step;
  logic [31:0] ea_addr;
  logic ea_upd;
  logic [31:0] ea_upd_val;

  always_comb begin
    ea_base = gr_ff[i_ea.idx];
    unique case (i_ea.size)
      SZ_BYTE: ea_step = STEP_B;
      SZ_WORD: ea_step = STEP_W;
      default: ea_step = STEP_L;
    endcase
    ea_upd = 1'b0;
    ea_upd_val = ea_base;
    ea_addr = ea_base;
    unique case (i_ea.mode)
      M_REG, M_IND: ea_addr = ea_base;
      M_DISP: ea_addr = ea_base + i_ea.disp;
      M_INCDEC: begin
        ea_upd = i_ea.valid;
        ea_upd_val = i_ea.dec ? ea_base - ea_step : ea_base + ea_step;
        ea_addr = i_ea.dec ? ea_upd_val : ea_base;
      end
      M_ABS, M_IMM: ea_addr = i_ea.disp;
      M_REL: ea_addr = {8'h00, o_fetch_ptr_ff} + i_ea.disp;
      M_MEMIND: ea_addr = {24'h000000, i_ea.disp[7:0]};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // General registers; the write port wins over an address step
  for (genvar g = 0; g < GR_NUM; g++) begin : g_gr
    always_comb begin
      nxt_gr[g] = gr_ff[g];
      if (ea_upd && i_ea.idx == 3'(g)) begin
        nxt_gr[g] = ea_upd_val;
      end
      if (i_gr_wr && i_gr_wr_sel.idx == 3'(g)) begin
        nxt_gr[g] = gr_merge(gr_ff[g], i_gr_wr_data, i_gr_wr_sel.part);
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    for (int k = 0; k < GR_NUM; k++) begin
      gr_ff[k] <= i_reset ? 32'h00000000 : nxt_gr[k];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag arithmetic
  int w;
  int hk;
  logic [31:0] szmask;
  logic [31:0] hmask;
  logic sub;
  logic cin;
  logic [31:0] a_op;
  logic [31:0] b_op;
  logic [32:0] sum;
  logic [32:0] hsum;
  logic [31:0] res;
  logic sa;
  logic sr;
  logic vflag;
  logic [7:0] bcd_adj;
  logic [7:0] bcd_res;

  always_comb begin
    unique case (i_alu.size)
      SZ_BYTE: begin w = 8; hk = HC_BYTE; end
      SZ_WORD: begin w = 16; hk = HC_WORD; end
      default: begin w = 32; hk = HC_LONG; end
    endcase
    szmask = 32'hffffffff >> (32 - w);
    hmask = 32'hffffffff >> (31 - hk);
    sub = i_alu.op inside {ALU_SUB, ALU_SUBC, ALU_CMP, ALU_NEG};
    cin = (i_alu.op inside {ALU_ADDC, ALU_SUBC}) & o_flags_ff[FLG_C];
    a_op = (i_alu.op == ALU_NEG) ? 32'h00000000 : (i_alu.a & szmask);
    b_op = i_alu.b & szmask;
    sum = sub ? {1'b0, a_op} - {1'b0, b_op} - {32'h0, cin}
              : {1'b0, a_op} + {1'b0, b_op} + {32'h0, cin};
    hsum = sub ? {1'b0, a_op & hmask} - {1'b0, b_op & hmask} - {32'h0, cin}
               : {1'b0, a_op & hmask} + {1'b0, b_op & hmask} + {32'h0, cin};
    res = sum[31:0] & szmask;
    sa = a_op[w-1];
    sr = res[w-1];
    vflag = sub ? (sa != b_op[w-1]) && (sr != sa) : (sa == b_op[w-1]) && (sr != sa);
    // Packed BCD digits, upper and lower nibble
    bcd_adj = 8'h00;
    if (o_flags_ff[FLG_H] || (i_alu.op == ALU_DEC_ADD && i_alu.a[3:0] > BCD_MAX)) begin
      bcd_adj = bcd_adj | BCD_LO_ADJ;
    end
    if (o_flags_ff[FLG_C] || (i_alu.op == ALU_DEC_ADD && i_alu.a[7:0] > BCD_PAIR_MAX)) begin
      bcd_adj = bcd_adj | BCD_HI_ADJ;
    end
    bcd_res = (i_alu.op == ALU_DEC_ADD) ? i_alu.a[7:0] + bcd_adj : i_alu.a[7:0] - bcd_adj;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control state and registered outputs
  logic [23:0] nxt_fp;
  logic [7:0] nxt_tml;
  logic [7:0] nxt_flags;
  logic [7:0] ctl_src;
  logic [7:0] ctl_val;
  logic ctl_wr;
  logic [31:0] nxt_res;
  logic nxt_take;

  always_comb begin
    nxt_fp = o_fetch_ptr_ff;
    if (i_fp_load) begin
      nxt_fp = i_fp_value;
    end else if (i_fp_step) begin
      nxt_fp = o_fetch_ptr_ff + FETCH_STEP;
    end
    nxt_flags = o_flags_ff;
    nxt_res = o_alu_res_ff;
    if (i_alu.valid) begin
      unique case (i_alu.op)
        ALU_ADD, ALU_ADDC, ALU_SUB, ALU_SUBC, ALU_CMP, ALU_NEG: begin
          nxt_res = res;
          nxt_flags[FLG_H] = hsum[hk+1];
          nxt_flags[FLG_V] = vflag;
          nxt_flags[FLG_C] = sum[w];
        end
        ALU_MOVE: begin
          nxt_res = b_op;
          nxt_flags[FLG_V] = 1'b0;
        end
        ALU_SHIFT: begin
          nxt_res = b_op;
          nxt_flags[FLG_V] = 1'b0;
          nxt_flags[FLG_C] = i_alu.shift_c;
        end
        ALU_BITLD: nxt_flags[FLG_C] = i_alu.a[i_alu.bit_sel];
        ALU_DEC_ADD: begin
          nxt_res = {24'h000000, bcd_res};
          nxt_flags[FLG_C] = o_flags_ff[FLG_C] | bcd_adj[5];
        end
        ALU_DEC_SUB: nxt_res = {24'h000000, bcd_res};
        default: nxt_res = o_alu_res_ff;
      endcase
      if (i_alu.op != ALU_BITLD) begin
        nxt_flags[FLG_N] = nxt_res[w-1];
        nxt_flags[FLG_Z] = ((nxt_res & szmask) == 32'h00000000);
      end
    end
    // Spare bits 6 and 4 change only here, and gate nothing
    ctl_src = i_ctl_tml ? o_tml_ff : o_flags_ff;
    ctl_wr = 1'b1;
    unique case (i_ctl_op)
      CTL_LOAD: ctl_val = i_ctl_imm;
      CTL_AND: ctl_val = ctl_src & i_ctl_imm;
      CTL_OR: ctl_val = ctl_src | i_ctl_imm;
      CTL_XOR: ctl_val = ctl_src ^ i_ctl_imm;
      default: begin
        ctl_val = ctl_src;
        ctl_wr = 1'b0;
      end
    endcase
    nxt_tml = o_tml_ff;
    if (ctl_wr && i_ctl_tml) begin
      nxt_tml = ctl_val & TML_WMASK;
    end
    if (ctl_wr && !i_ctl_tml) begin
      nxt_flags = ctl_val;
    end
    if (i_exc_start) begin
      nxt_flags[FLG_I] = 1'b1;
    end
    if (ctl_wr && i_ctl_tml) begin
      nxt_hold = HOLD_CNT[1:0];
    end else begin
      nxt_hold = (hold_ff != 2'h0) ? hold_ff - 2'h1 : 2'h0;
    end
    nxt_take = (hold_ff == 2'h0) && (i_nmi || (i_irq_req && !o_flags_ff[FLG_I]
                && i_irq_level > o_tml_ff[TML_LVL_HI:0]));
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_fetch_ptr_ff <= FP_RST;
      o_fetch_addr_ff <= FP_RST;
      o_tml_ff <= TML_RST;
      o_flags_ff <= FLG_RST;
      o_alu_res_ff <= 32'h00000000;
      o_ctl_rd_ff <= 8'h00;
      o_gr_rd_ff <= 32'h00000000;
      o_ea_addr_ff <= 32'h00000000;
      o_ea_valid_ff <= 1'b0;
      o_irq_take_ff <= 1'b0;
      o_trace_req_ff <= 1'b0;
      hold_ff <= 2'h0;
    end else begin
      o_fetch_ptr_ff <= nxt_fp;
      o_fetch_addr_ff <= {nxt_fp[23:1], 1'b0};
      o_tml_ff <= nxt_tml;
      o_flags_ff <= nxt_flags;
      o_alu_res_ff <= nxt_res;
      o_ctl_rd_ff <= (i_ctl_op == CTL_STORE) ? ctl_src : o_ctl_rd_ff;
      o_gr_rd_ff <= gr_pick(gr_ff[i_gr_rd_sel.idx], i_gr_rd_sel.part);
      o_ea_addr_ff <= i_ea.valid ? ea_addr : o_ea_addr_ff;
      o_ea_valid_ff <= i_ea.valid;
      o_irq_take_ff <= nxt_take;
      o_trace_req_ff <= i_instr_done && o_tml_ff[TML_TRACE];
      hold_ff <= nxt_hold;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic chk_hc_byte;
  logic [31:0] chk_dec_addr;
  logic clean_alu;
  assign chk_hc_byte = ({1'b0, i_alu.a[3:0]} + {1'b0, i_alu.b[3:0]}) > 5'h0f;
  assign chk_dec_addr = gr_ff[i_ea.idx] - STEP_L;
  assign clean_alu = i_alu.valid && i_ctl_op == CTL_NONE && !i_exc_start;

  a_fetch_even: assert property (@(posedge i_mclk) disable iff (i_reset)
    !o_fetch_addr_ff[0]) else $error("fetch address odd");
  a_hold_window: assert property (@(posedge i_mclk) disable iff (i_reset)
    (ctl_wr && i_ctl_tml) |=> ##1 !o_irq_take_ff [*3]) else $error("interrupt in holdoff");
  a_nmi_taken: assert property (@(posedge i_mclk) disable iff (i_reset)
    (hold_ff == 2'h0 && i_nmi) |=> o_irq_take_ff) else $error("nmi not taken");
  a_i_masks: assert property (@(posedge i_mclk) disable iff (i_reset)
    (o_flags_ff[FLG_I] && !i_nmi) |=> !o_irq_take_ff) else $error("masked irq taken");
  a_exc_sets_i: assert property (@(posedge i_mclk) disable iff (i_reset)
    i_exc_start |=> o_flags_ff[FLG_I]) else $error("exception left I clear");
  a_trace_req: assert property (@(posedge i_mclk) disable iff (i_reset)
    i_instr_done |=> (o_trace_req_ff == $past(o_tml_ff[TML_TRACE]))) else $error("trace wrong");
  a_zero_flag: assert property (@(posedge i_mclk) disable iff (i_reset)
    (clean_alu && i_alu.op == ALU_MOVE) |=> (o_flags_ff[FLG_Z] == (o_alu_res_ff == 32'h0)))
    else $error("zero flag wrong");
  a_move_keeps: assert property (@(posedge i_mclk) disable iff (i_reset)
    (clean_alu && i_alu.op == ALU_MOVE) |=> ($stable(o_flags_ff[FLG_C])
    && !o_flags_ff[FLG_V] && $stable(o_flags_ff[FLG_H]))) else $error("move flags wrong");
  a_byte_half: assert property (@(posedge i_mclk) disable iff (i_reset)
    (clean_alu && i_alu.op == ALU_ADD && i_alu.size == SZ_BYTE)
    |=> (o_flags_ff[FLG_H] == $past(chk_hc_byte))) else $error("byte half-carry wrong");
  a_predec_long: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_ea.valid && i_ea.mode == M_INCDEC && i_ea.dec && i_ea.size == SZ_LONG)
    |=> (o_ea_addr_ff == $past(chk_dec_addr))) else $error("pre-decrement step wrong");
endmodule

// [rtl/cpurs_pkg.sv]
// Constants, enumerations and carriers of the CPU programmer-visible state.
// Assumes one clock and a synchronous reset; used by cpurs_core and its bench.
package cpurs_pkg;
  localparam int GR_NUM = 8;
  localparam int GR_W = 32;
  localparam int FP_W = 24;
  localparam int CR_W = 8;
  // Trace and mask level fields
  localparam int TML_TRACE = 7;
  localparam int TML_LVL_HI = 2;
  localparam logic [7:0] TML_WMASK = 8'h87;
  localparam logic [7:0] TML_RST = 8'h07;
  // Condition flag fields
  localparam int FLG_I = 7;
  localparam int FLG_SPARE6 = 6;
  localparam int FLG_U = 4;
  localparam int FLG_H = 5;
  localparam int FLG_N = 3;
  localparam int FLG_Z = 2;
  localparam int FLG_V = 1;
  localparam int FLG_C = 0;
  localparam logic [7:0] FLG_RST = 8'h80;
  // Half-carry positions per size
  localparam int HC_BYTE = 3;
  localparam int HC_WORD = 11;
  localparam int HC_LONG = 27;
  localparam int HOLD_STATES = 3;
  localparam logic [23:0] FP_RST = 24'h000000;
  localparam logic [23:0] FETCH_STEP = 24'h000002;
  localparam logic [31:0] STEP_B = 32'h00000001;
  localparam logic [31:0] STEP_W = 32'h00000002;
  localparam logic [31:0] STEP_L = 32'h00000004;
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [7:0] BCD_PAIR_MAX = 8'h99;
  localparam logic [7:0] BCD_LO_ADJ = 8'h06;
  localparam logic [7:0] BCD_HI_ADJ = 8'h60;

  typedef enum logic [2:0] {
    PART_LONG = 3'h0, PART_UPPER = 3'h1, PART_LOWER = 3'h2,
    PART_HIGH = 3'h3, PART_LOW = 3'h4
  } cpurs_part_t;
  typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2} cpurs_size_t;
  typedef enum logic [3:0] {
    ALU_ADD = 4'h0, ALU_ADDC = 4'h1, ALU_SUB = 4'h2, ALU_SUBC = 4'h3,
    ALU_CMP = 4'h4, ALU_NEG = 4'h5, ALU_MOVE = 4'h6, ALU_SHIFT = 4'h7,
    ALU_BITLD = 4'h8, ALU_DEC_ADD = 4'h9, ALU_DEC_SUB = 4'ha
  } cpurs_alu_op_t;
  typedef enum logic [2:0] {
    CTL_NONE = 3'h0, CTL_LOAD = 3'h1, CTL_STORE = 3'h2,
    CTL_AND = 3'h3, CTL_OR = 3'h4, CTL_XOR = 3'h5
  } cpurs_ctl_op_t;
  typedef enum logic [2:0] {
    M_REG = 3'h0, M_IND = 3'h1, M_DISP = 3'h2, M_INCDEC = 3'h3,
    M_ABS = 3'h4, M_IMM = 3'h5, M_REL = 3'h6, M_MEMIND = 3'h7
  } cpurs_mode_t;

  typedef struct packed {
    logic [2:0] idx;
    cpurs_part_t part;
  } cpurs_gr_sel_t;
  typedef struct packed {
    logic valid;
    cpurs_alu_op_t op;
    cpurs_size_t size;
    logic [31:0] a;
    logic [31:0] b;
    logic shift_c;
    logic [2:0] bit_sel;
  } cpurs_alu_req_t;
  typedef struct packed {
    logic valid;
    cpurs_mode_t mode;
    logic [2:0] idx;
    cpurs_size_t size;
    logic dec;
    logic [31:0] disp;
  } cpurs_ea_req_t;
endpackage

// [verif/cpu_register_state_test.sv]
// Self-checking bench for cpurs_core; the bench drives every port itself.
// Assumes rtl/cpurs_pkg.sv and rtl/cpurs_core.sv; inputs move at falling edges.
`timescale 1ns/100ps
module cpu_register_state_test;
  import cpurs_pkg::*;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic gr_wr = 1'b0;
  cpurs_gr_sel_t wr_sel = '0;
  logic [31:0] wr_data = '0;
  cpurs_gr_sel_t rd_sel = '0;
  cpurs_ea_req_t ea = '0;
  logic fp_load = 1'b0;
  logic fp_step = 1'b0;
  logic [23:0] fp_val = '0;
  cpurs_ctl_op_t cop = CTL_NONE;
  logic ctml = 1'b0;
  logic [7:0] cimm = '0;
  cpurs_alu_req_t alu = '0;
  logic done = 1'b0;
  logic exc = 1'b0;
  logic nmi = 1'b0;
  logic irq = 1'b0;
  logic [2:0] lvl = '0;
  logic [31:0] rd, ea_addr, res;
  logic ea_v, take, trc;
  logic [23:0] fptr, faddr;
  logic [7:0] crd, tml, flg;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #5 i_mclk = ~i_mclk;

  cpurs_core dut (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_gr_wr(gr_wr),
    .i_gr_wr_sel(wr_sel),
    .i_gr_wr_data(wr_data),
    .i_gr_rd_sel(rd_sel),
    .o_gr_rd_ff(rd),
    .i_ea(ea),
    .o_ea_valid_ff(ea_v),
    .o_ea_addr_ff(ea_addr),
    .i_fp_load(fp_load),
    .i_fp_value(fp_val),
    .i_fp_step(fp_step),
    .o_fetch_ptr_ff(fptr),
    .o_fetch_addr_ff(faddr),
    .i_ctl_op(cop),
    .i_ctl_tml(ctml),
    .i_ctl_imm(cimm),
    .o_ctl_rd_ff(crd),
    .o_tml_ff(tml),
    .o_flags_ff(flg),
    .i_alu(alu),
    .o_alu_res_ff(res),
    .i_instr_done(done),
    .i_exc_start(exc),
    .i_nmi(nmi),
    .i_irq_req(irq),
    .i_irq_level(lvl),
    .o_irq_take_ff(take),
    .o_trace_req_ff(trc)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge i_mclk);
  endtask

  task automatic grw(input logic [2:0] ix, input cpurs_part_t pt, input logic [31:0] d);
    @(negedge i_mclk);
    gr_wr = 1'b1;
    wr_sel = '{ix, pt};
    wr_data = d;
    @(negedge i_mclk);
    gr_wr = 1'b0;
  endtask

  task automatic grr(input logic [2:0] ix, input cpurs_part_t pt, input logic [31:0] e);
    @(negedge i_mclk);
    rd_sel = '{ix, pt};
    @(negedge i_mclk);
    chk("gr read", e, rd);
  endtask

  task automatic fpq(input logic ld, input logic st, input logic [23:0] v,
                     input logic [23:0] e);
    @(negedge i_mclk);
    fp_load = ld;
    fp_step = st;
    fp_val = v;
    @(negedge i_mclk);
    fp_load = 1'b0;
    fp_step = 1'b0;
    chk("fetch ptr", e, fptr);
    chk("fetch addr", {e[23:1], 1'b0}, faddr);
  endtask

  task automatic eaq(input cpurs_mode_t m, input cpurs_size_t s, input logic dc,
                     input logic [31:0] dp, input logic [31:0] e);
    @(negedge i_mclk);
    ea = '{1'b1, m, 3'h2, s, dc, dp};
    @(negedge i_mclk);
    ea.valid = 1'b0;
    chk("ea valid", 32'h1, ea_v);
    chk("ea addr", e, ea_addr);
  endtask

  // Ops with no register target leave the result unchecked (rc low)
  // Shifted-out carry bit rides on bit 0 of a
  task automatic op(input cpurs_alu_op_t o, input cpurs_size_t s, input logic [31:0] a,
                    input logic [31:0] b, input logic [2:0] bs, input logic rc,
                    input logic [31:0] er, input logic [7:0] m, input logic [7:0] ef);
    @(negedge i_mclk);
    alu = '{1'b1, o, s, a, b, a[0], bs};
    @(negedge i_mclk);
    alu.valid = 1'b0;
    if (rc) chk("alu result", er, res);
    chk("alu flags", ef, flg & m);
  endtask

  // Control op, then three cycles of interrupt acceptance, then settle
  task automatic ctlh(input cpurs_ctl_op_t o, input logic t, input logic [7:0] im,
                      input logic [7:0] er, input logic hz);
    @(negedge i_mclk);
    cop = o;
    ctml = t;
    cimm = im;
    @(negedge i_mclk);
    cop = CTL_NONE;
    chk("control reg", er, t ? tml : flg);
    repeat (3) begin
      tick(1);
      chk("irq take", hz, take);
    end
    tick(2);
  endtask

  task automatic trq(input logic e);
    @(negedge i_mclk);
    done = 1'b1;
    @(negedge i_mclk);
    done = 1'b0;
    chk("trace req", e, trc);
    tick(1);
    chk("trace drop", 32'h0, trc);
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Whole run is a few hundred cycles; ceiling leaves wide margin
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      print_verdict();
    end
  end

  initial begin
    tick(5);
    i_reset = 1'b0;
    chk("tml reset", 32'h07, tml);
    chk("flags reset", 32'h80, flg);
    chk("fp reset", 32'h0, fptr);
    grr(3'h3, PART_LONG, 32'h0);
    grw(3'h3, PART_LONG, 32'h12345678);
    grr(3'h3, PART_UPPER, 32'h1234);
    grr(3'h3, PART_LOWER, 32'h5678);
    grr(3'h3, PART_HIGH, 32'h56);
    grr(3'h3, PART_LOW, 32'h78);
    grw(3'h3, PART_HIGH, 32'h000000ab);
    grw(3'h3, PART_UPPER, 32'h0000cdef);
    grw(3'h3, PART_LOW, 32'hffffff11);
    grw(3'h3, cpurs_part_t'(3'h5), 32'h0);
    grr(3'h3, PART_LONG, 32'hcdefab11);
    grw(3'h5, PART_LOWER, 32'hffff0042);
    grr(3'h5, PART_LONG, 32'h00000042);
    grr(3'h4, PART_LONG, 32'h0);
    fpq(1'b1, 1'b0, 24'h001235, 24'h001235);
    fpq(1'b0, 1'b1, 24'h0, 24'h001237);
    fpq(1'b1, 1'b1, 24'h000101, 24'h000101);
    grw(3'h2, PART_LONG, 32'h00001000);
    eaq(M_REG, SZ_LONG, 1'b0, 32'h0, 32'h00001000);
    eaq(M_IND, SZ_LONG, 1'b0, 32'h0, 32'h00001000);
    eaq(M_DISP, SZ_LONG, 1'b0, 32'h10, 32'h00001010);
    eaq(M_ABS, SZ_LONG, 1'b0, 32'h00abcdef, 32'h00abcdef);
    eaq(M_IMM, SZ_BYTE, 1'b0, 32'h55, 32'h55);
    eaq(M_REL, SZ_WORD, 1'b0, 32'h10, 32'h00000111);
    eaq(M_MEMIND, SZ_LONG, 1'b0, 32'h1234, 32'h34);
    eaq(M_INCDEC, SZ_BYTE, 1'b0, 32'h0, 32'h00001000);
    grr(3'h2, PART_LONG, 32'h00001001);
    eaq(M_INCDEC, SZ_LONG, 1'b1, 32'h0, 32'h00000ffd);
    grr(3'h2, PART_LONG, 32'h00000ffd);
    eaq(M_INCDEC, SZ_WORD, 1'b0, 32'h0, 32'h00000ffd);
    tick(1);
    chk("ea pulse", 32'h0, ea_v);
    grr(3'h2, PART_LONG, 32'h00000fff);
    ctlh(CTL_LOAD, 1'b1, 8'hff, 8'h87, 1'b0);
    trq(1'b1);
    ctlh(CTL_LOAD, 1'b1, 8'h03, 8'h03, 1'b0);
    trq(1'b0);
    nmi = 1'b1;
    tick(2);
    chk("nmi take", 32'h1, take);
    ctlh(CTL_LOAD, 1'b1, 8'h83, 8'h83, 1'b0);
    chk("nmi back", 32'h1, take);
    ctlh(CTL_STORE, 1'b1, 8'h00, 8'h83, 1'b1);
    chk("store read", 32'h83, crd);
    ctlh(CTL_AND, 1'b1, 8'h07, 8'h03, 1'b0);
    ctlh(CTL_OR, 1'b1, 8'h04, 8'h07, 1'b0);
    ctlh(CTL_XOR, 1'b1, 8'h04, 8'h03, 1'b0);
    ctlh(CTL_LOAD, 1'b0, 8'h00, 8'h00, 1'b1);
    nmi = 1'b0;
    irq = 1'b1;
    lvl = 3'h5;
    tick(2);
    chk("irq above mask", 32'h1, take);
    ctlh(CTL_LOAD, 1'b0, 8'h80, 8'h80, 1'b0);
    ctlh(CTL_LOAD, 1'b0, 8'h40, 8'h40, 1'b1);
    ctlh(CTL_OR, 1'b0, 8'h10, 8'h50, 1'b1);
    ctlh(CTL_XOR, 1'b0, 8'h40, 8'h10, 1'b1);
    ctlh(CTL_STORE, 1'b0, 8'h00, 8'h10, 1'b1);
    chk("store read", 32'h10, crd);
    ctlh(CTL_AND, 1'b0, 8'hef, 8'h00, 1'b1);
    lvl = 3'h3;
    tick(2);
    chk("irq at mask", 32'h0, take);
    lvl = 3'h4;
    tick(2);
    chk("irq over mask", 32'h1, take);
    @(negedge i_mclk);
    exc = 1'b1;
    @(negedge i_mclk);
    exc = 1'b0;
    tick(1);
    chk("exc sets mask", 32'h80, flg & 8'h80);
    chk("irq masked", 32'h0, take);
    irq = 1'b0;
    op(ALU_ADD, SZ_BYTE, 32'h0f, 32'h01, 3'h0, 1'b1, 32'h10, 8'h2f, 8'h20);
    op(ALU_ADD, SZ_WORD, 32'h0fff, 32'h1, 3'h0, 1'b1, 32'h1000, 8'h2f, 8'h20);
    op(ALU_ADD, SZ_LONG, 32'h0fffffff, 32'h1, 3'h0, 1'b1, 32'h10000000, 8'h2f, 8'h20);
    op(ALU_ADD, SZ_BYTE, 32'h7f, 32'h01, 3'h0, 1'b1, 32'h80, 8'h2f, 8'h2a);
    op(ALU_MOVE, SZ_WORD, 32'h0, 32'h0, 3'h0, 1'b1, 32'h0, 8'h2f, 8'h24);
    op(ALU_ADD, SZ_BYTE, 32'hff, 32'h01, 3'h0, 1'b1, 32'h00, 8'h2f, 8'h25);
    op(ALU_ADDC, SZ_BYTE, 32'h0e, 32'h01, 3'h0, 1'b1, 32'h10, 8'h2f, 8'h20);
    op(ALU_NEG, SZ_BYTE, 32'h0, 32'h01, 3'h0, 1'b1, 32'hff, 8'h2f, 8'h29);
    op(ALU_SUBC, SZ_BYTE, 32'h10, 32'h0, 3'h0, 1'b1, 32'h0f, 8'h2f, 8'h20);
    op(ALU_SUB, SZ_WORD, 32'h1000, 32'h1, 3'h0, 1'b1, 32'h0fff, 8'h2f, 8'h20);
    op(ALU_CMP, SZ_LONG, 32'h10000000, 32'h1, 3'h0, 1'b1, 32'h0fffffff, 8'h2f, 8'h20);
    op(ALU_SHIFT, SZ_BYTE, 32'h1, 32'h80, 3'h0, 1'b1, 32'h80, 8'h0f, 8'h09);
    op(ALU_SHIFT, SZ_BYTE, 32'h0, 32'h01, 3'h0, 1'b1, 32'h01, 8'h0f, 8'h00);
    op(ALU_BITLD, SZ_BYTE, 32'h08, 32'h0, 3'h3, 1'b0, 32'h0, 8'h01, 8'h01);
    op(ALU_BITLD, SZ_BYTE, 32'h08, 32'h0, 3'h2, 1'b0, 32'h0, 8'h01, 8'h00);
    op(ALU_ADD, SZ_BYTE, 32'h01, 32'h01, 3'h0, 1'b1, 32'h02, 8'h2f, 8'h00);
    op(ALU_DEC_ADD, SZ_BYTE, 32'h9a, 32'h0, 3'h0, 1'b1, 32'h00, 8'h0d, 8'h05);
    op(ALU_SUB, SZ_BYTE, 32'h10, 32'h01, 3'h0, 1'b1, 32'h0f, 8'h2f, 8'h20);
    op(ALU_DEC_SUB, SZ_BYTE, 32'h0f, 32'h0, 3'h0, 1'b1, 32'h09, 8'h0c, 8'h00);
    print_verdict();
  end
endmodule
